/* common/bac_pkg.sv */
package bac_pkg;
	// channel count and datapath widths
	localparam int NCH = 4;
	localparam int VAL_W = 16;
	localparam int EXT_W = VAL_W + 2;
	localparam int SCYC_W = 5;
	localparam int WIN_W = 12;
	// register offsets on the serial port
	localparam logic [7:0] OFS_DIV = 8'h17;
	localparam logic [7:0] OFS_BAND = 8'h18;
	localparam logic [7:0] OFS_TWIST = 8'h19;
	localparam logic [7:0] OFS_GROUP = 8'h1a;
	localparam logic [7:0] OFS_SIGN = 8'h1c;
	// reset values
	localparam logic [7:0] RST_DIV = 8'h03;
	localparam logic [7:0] RST_BAND = 8'h08;
	localparam logic [7:0] RST_TWIST = 8'h00;
	localparam logic [7:0] RST_GROUP = 8'h00;
	localparam logic [7:0] RST_SIGN = 8'h0f;
	// value returned for an unmapped offset
	localparam logic [7:0] RD_NONE = 8'h00;
	// field layout
	localparam int FLD_LSB = 0;
	localparam int DIV_W = 3;
	localparam int BAND_W = 4;
	localparam int TWIST_W = 3;
	localparam int COM_LSB = 4;
	localparam int DEF_LSB = 0;
	localparam int OPOL_LSB = 4;
	localparam int DPOL_LSB = 0;
	// band and twist fields count in steps of four
	localparam logic [1:0] SCALE_PAD = 2'h0;
	// serial bus constants
	localparam logic [6:0] BUS_ADDR = 7'h2a;
	localparam logic [3:0] BITS_BYTE = 4'h8;
	localparam logic [3:0] BIT_TOP = 4'h7;
	// pins idle released while polarity is active low
	localparam logic [NCH-1:0] PIN_RST = 4'hf;

	// serial port states, gray along the usual path
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_ACK = 3'h3,
		ST_WDATA = 3'h2,
		ST_RDATA = 3'h7,
		ST_RACK = 3'h5
	} bac_i2c_state_t;

	// configuration fields seen by the algorithm
	typedef struct packed {
		logic [DIV_W-1:0] osc_divider_sel;
		logic [BAND_W-1:0] trigger_band;
		logic [TWIST_W-1:0] twist_guard_level;
		logic [NCH-1:0] common_group_member;
		logic [NCH-1:0] deform_group_member;
		logic [NCH-1:0] output_pin_polarity;
		logic [NCH-1:0] data_sign_select;
	} bac_cfg_t;
endpackage

/* logic/bac_sync.sv */
`timescale 1ns/10ps
module bac_sync import bac_pkg::*; #(
	parameter int W = 2,
	parameter logic [W-1:0] RST = '1
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// raw and settled levels
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	// two stage chain state
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stab;
	} bac_sync_t;

	bac_sync_t st_r;
	bac_sync_t st_nxt;

	// first stage feeds only the second
	always_comb begin
		st_nxt.meta = i_d;
		st_nxt.stab = st_r.meta;
	end

	// register the chain
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			st_r <= '{meta: RST, stab: RST};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_q = st_r.stab;
endmodule

/* logic/bac_btn_eval.sv */
`timescale 1ns/10ps
module bac_btn_eval import bac_pkg::*; (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// configuration
	input wire bac_cfg_t i_cfg,
	// processed samples
	input wire logic i_valid,
	input wire logic [NCH-1:0][VAL_W-1:0] i_value,
	input wire logic [VAL_W-1:0] i_threshold,
	// results
	output logic [NCH-1:0] o_pin,
	output logic o_twist_void
);
	// evaluator state
	typedef struct packed {
		logic [NCH-1:0] pressed;
		logic [NCH-1:0] pin;
		logic void_f;
	} bac_eval_t;

	bac_eval_t st_r;
	bac_eval_t st_nxt;
	logic signed [EXT_W-1:0] press_lvl; // trigger level
	logic signed [EXT_W-1:0] hold_lvl; // release level below trigger
	logic signed [EXT_W-1:0] tw_lim; // twist threshold
	logic twist_on; // twist check enabled
	logic [NCH-1:0] neg_trip; // channel too negative
	logic [NCH-1:0] press_ok; // at or above trigger
	logic [NCH-1:0] hold_ok; // still inside band

	// hysteresis is four times the band field
	assign press_lvl = EXT_W'(signed'(i_threshold));
	assign hold_lvl = press_lvl - EXT_W'({i_cfg.trigger_band, SCALE_PAD});
	// twist threshold is four times its field
	assign tw_lim = EXT_W'({i_cfg.twist_guard_level, SCALE_PAD});
	// a zero field turns the twist check off
	assign twist_on = |i_cfg.twist_guard_level;

	// per channel sign select and level compares
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		logic signed [EXT_W-1:0] v;
		// a clear sign select bit negates the processed value
		assign v = i_cfg.data_sign_select[c] ? EXT_W'(signed'(i_value[c]))
			: -EXT_W'(signed'(i_value[c]));
		// every channel is checked, no subset
		assign neg_trip[c] = v < -tw_lim;
		assign press_ok[c] = v >= press_lvl;
		assign hold_ok[c] = v >= hold_lvl;
	end

	// press, release and twist voiding
	always_comb begin
		st_nxt = st_r;
		if (i_valid) begin
			// one channel below minus the twist threshold voids all buttons
			st_nxt.void_f = twist_on && (|neg_trip);
			if (st_nxt.void_f) begin
				st_nxt.pressed = '0;
			end else begin
				st_nxt.pressed = (st_r.pressed & hold_ok) | press_ok;
			end
		end
		// pin level from output polarity
		st_nxt.pin = ~(st_nxt.pressed ^ i_cfg.output_pin_polarity);
	end

	// register state
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			st_r <= '{pressed: '0, pin: PIN_RST, void_f: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_pin = st_r.pin;
	assign o_twist_void = st_r.void_f;

	twist_off_a: assert property (
		@(posedge i_clk) disable iff (i_reset)
		(i_valid && i_cfg.twist_guard_level == '0) |=> !o_twist_void
	) else $error("twist void with check disabled");

	twist_void_a: assert property (
		@(posedge i_clk) disable iff (i_reset)
		(i_valid && twist_on && neg_trip != '0) |=>
			(st_r.pressed == '0 && o_pin == ~$past(i_cfg.output_pin_polarity))
	) else $error("twist trip did not release all buttons");

	band_release_a: assert property (
		@(posedge i_clk) disable iff (i_reset)
		(i_valid && !hold_ok[0] && !press_ok[0]) |=> !st_r.pressed[0]
	) else $error("button held below hysteresis band");
endmodule

/* logic/bac_cfg_top.sv */
`timescale 1ns/10ps
module bac_cfg_top import bac_pkg::*; (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// serial register port
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe,
	// algorithm inputs
	input wire logic [NCH-1:0][SCYC_W-1:0] i_sensor_cycle_count,
	input wire logic i_value_valid,
	input wire logic [NCH-1:0][VAL_W-1:0] i_button_value,
	input wire logic [VAL_W-1:0] i_trigger_threshold,
	// configuration and results
	output bac_cfg_t o_cfg,
	output logic [NCH-1:0][WIN_W-1:0] o_sample_window,
	output logic [NCH-1:0] o_button_output_pin,
	output logic o_twist_void
);
	// whole block state
	typedef struct packed {
		bac_i2c_state_t fsm;
		logic [3:0] bitcnt;
		logic [7:0] shift;
		logic [7:0] ptr;
		logic rw;
		logic ptr_set;
		logic scl_q;
		logic sda_q;
		logic sda_o;
		logic sda_oe;
		logic [7:0] r_div;
		logic [7:0] r_band;
		logic [7:0] r_twist;
		logic [7:0] r_group;
		logic [7:0] r_sign;
		logic [NCH-1:0][WIN_W-1:0] win;
	} bac_top_t;

	// reset image, bus lines idle high
	localparam bac_top_t TOP_RST = '{
		fsm: ST_IDLE,
		scl_q: 1'b1,
		sda_q: 1'b1,
		r_div: RST_DIV,
		r_band: RST_BAND,
		r_twist: RST_TWIST,
		r_group: RST_GROUP,
		r_sign: RST_SIGN,
		default: '0
	};

	bac_top_t st_r;
	bac_top_t st_nxt;
	logic [1:0] bus_s; // settled scl and sda
	logic scl_s; // settled clock line
	logic sda_s; // settled data line
	logic scl_rise; // clock rising edge
	logic scl_fall; // clock falling edge
	logic bus_start; // start condition
	logic bus_stop; // stop condition
	logic wr_hit; // register write this cycle
	logic [NCH-1:0][WIN_W-1:0] win_w; // window per channel

	// read mux; unmapped offsets read as zero
	function automatic logic [7:0] rd_byte(input logic [7:0] a, input bac_top_t s);
		logic [7:0] d;
		d = RD_NONE;
		unique case (a)
			OFS_DIV: d = s.r_div;
			OFS_BAND: d = s.r_band;
			OFS_TWIST: d = s.r_twist;
			OFS_GROUP: d = s.r_group;
			OFS_SIGN: d = s.r_sign;
			default: d = RD_NONE;
		endcase
		return d;
	endfunction

	// pins pass two flops before any use
	bac_sync #(
		.W(2),
		.RST(2'h3)
	) u_sync (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_d({i_scl, i_sda}),
		.o_q(bus_s)
	);

	assign scl_s = bus_s[1];
	assign sda_s = bus_s[0];
	// edges and bus conditions from settled lines
	assign scl_rise = scl_s && !st_r.scl_q;
	assign scl_fall = !scl_s && st_r.scl_q;
	assign bus_start = scl_s && st_r.scl_q && st_r.sda_q && !sda_s;
	assign bus_stop = scl_s && st_r.scl_q && !st_r.sda_q && sda_s;

	// window length: cycle count scaled by divider
	for (genvar c = 0; c < NCH; c++) begin : g_win
		assign win_w[c] = WIN_W'(i_sensor_cycle_count[c])
			<< st_r.r_div[FLD_LSB +: DIV_W];
	end

	// serial protocol and register writes
	always_comb begin
		st_nxt = st_r;
		wr_hit = 1'b0;
		st_nxt.scl_q = scl_s;
		st_nxt.sda_q = sda_s;
		st_nxt.win = win_w;
		st_nxt.sda_o = 1'b0;
		if (bus_start) begin
			// start or repeated start
			st_nxt.fsm = ST_ADDR;
			st_nxt.bitcnt = '0;
			st_nxt.ptr_set = 1'b0;
			st_nxt.sda_oe = 1'b0;
		end else if (bus_stop) begin
			// stop ends any transfer
			st_nxt.fsm = ST_IDLE;
			st_nxt.sda_oe = 1'b0;
		end else begin
			unique case (st_r.fsm)
				ST_IDLE: begin
					st_nxt.sda_oe = 1'b0;
				end
				ST_ADDR, ST_WDATA: begin
					if (scl_rise && st_r.bitcnt != BITS_BYTE) begin
						// shift in msb first
						st_nxt.shift = {st_r.shift[6:0], sda_s};
						st_nxt.bitcnt = st_r.bitcnt + 4'h1;
					end else if (scl_fall && st_r.bitcnt == BITS_BYTE) begin
						st_nxt.bitcnt = '0;
						if (st_r.fsm == ST_ADDR) begin
							if (st_r.shift[7:1] == BUS_ADDR) begin
								// our address: acknowledge
								st_nxt.rw = st_r.shift[0];
								st_nxt.fsm = ST_ACK;
								st_nxt.sda_oe = 1'b1;
								st_nxt.shift = rd_byte(st_r.ptr, st_r);
							end else begin
								// other device: ignore until start
								st_nxt.fsm = ST_IDLE;
							end
						end else if (!st_r.ptr_set) begin
							// first byte selects the register
							st_nxt.ptr = st_r.shift;
							st_nxt.ptr_set = 1'b1;
							st_nxt.fsm = ST_ACK;
							st_nxt.sda_oe = 1'b1;
						end else begin
							// later bytes write and advance
							wr_hit = 1'b1;
							unique case (st_r.ptr)
								OFS_DIV: st_nxt.r_div = st_r.shift;
								OFS_BAND: st_nxt.r_band = st_r.shift;
								OFS_TWIST: st_nxt.r_twist = st_r.shift;
								OFS_GROUP: st_nxt.r_group = st_r.shift;
								OFS_SIGN: st_nxt.r_sign = st_r.shift;
								default: st_nxt.ptr_set = 1'b1;
							endcase
							st_nxt.ptr = st_r.ptr + 8'h01;
							st_nxt.fsm = ST_ACK;
							st_nxt.sda_oe = 1'b1;
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						// release ack, go on in direction asked
						if (st_r.rw) begin
							st_nxt.fsm = ST_RDATA;
							st_nxt.sda_oe = ~st_r.shift[7];
						end else begin
							st_nxt.fsm = ST_WDATA;
							st_nxt.sda_oe = 1'b0;
						end
					end
				end
				ST_RDATA: begin
					if (scl_rise) begin
						st_nxt.bitcnt = st_r.bitcnt + 4'h1;
					end else if (scl_fall) begin
						if (st_r.bitcnt == BITS_BYTE) begin
							// byte sent, let master answer
							st_nxt.sda_oe = 1'b0;
							st_nxt.fsm = ST_RACK;
						end else begin
							// drive next bit, low only
							st_nxt.sda_oe = ~st_r.shift[3'(BIT_TOP - st_r.bitcnt)];
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						if (sda_s) begin
							// not acknowledged: stop sending
							st_nxt.fsm = ST_IDLE;
						end else begin
							// acknowledged: fetch next register
							st_nxt.ptr = st_r.ptr + 8'h01;
							st_nxt.shift = rd_byte(st_r.ptr + 8'h01, st_r);
							st_nxt.bitcnt = '0;
						end
					end else if (scl_fall) begin
						st_nxt.fsm = ST_RDATA;
						st_nxt.sda_oe = ~st_r.shift[7];
					end
				end
				default: begin
					// illegal code recovers to idle
					st_nxt.fsm = ST_IDLE;
					st_nxt.sda_oe = 1'b0;
				end
			endcase
		end
	end

	// register the whole state
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			st_r <= TOP_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// button evaluation from current fields
	bac_btn_eval u_eval (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_cfg(o_cfg),
		.i_valid(i_value_valid),
		.i_value(i_button_value),
		.i_threshold(i_trigger_threshold),
		.o_pin(o_button_output_pin),
		.o_twist_void(o_twist_void)
	);

	// fields straight off the registers
	assign o_cfg.osc_divider_sel = st_r.r_div[FLD_LSB +: DIV_W];
	assign o_cfg.trigger_band = st_r.r_band[FLD_LSB +: BAND_W];
	assign o_cfg.twist_guard_level = st_r.r_twist[FLD_LSB +: TWIST_W];
	assign o_cfg.common_group_member = st_r.r_group[COM_LSB +: NCH];
	assign o_cfg.deform_group_member = st_r.r_group[DEF_LSB +: NCH];
	assign o_cfg.output_pin_polarity = st_r.r_sign[OPOL_LSB +: NCH];
	assign o_cfg.data_sign_select = st_r.r_sign[DPOL_LSB +: NCH];
	assign o_sample_window = st_r.win;
	assign o_sda = st_r.sda_o;
	assign o_sda_oe = st_r.sda_oe;

	reset_vals_a: assert property (
		@(posedge i_clk) disable iff (i_reset)
		$past(i_reset) |-> (st_r.r_div == RST_DIV && st_r.r_band == RST_BAND
			&& st_r.r_twist == RST_TWIST && st_r.r_group == RST_GROUP
			&& st_r.r_sign == RST_SIGN && !o_sda_oe)
	) else $error("register not at reset value");

	window_len_a: assert property (
		@(posedge i_clk) disable iff (i_reset)
		!$past(i_reset) |-> o_sample_window[0] ==
			(WIN_W'($past(i_sensor_cycle_count[0])) << $past(o_cfg.osc_divider_sel))
	) else $error("sampling window mismatch");

	group_wr_a: assert property (
		@(posedge i_clk) disable iff (i_reset)
		(wr_hit && st_r.ptr == OFS_GROUP) |=>
			(o_cfg.common_group_member == $past(st_r.shift[7:4])
			&& o_cfg.deform_group_member == $past(st_r.shift[3:0]))
	) else $error("group masks not written");

	sign_wr_a: assert property (
		@(posedge i_clk) disable iff (i_reset)
		(wr_hit && st_r.ptr == OFS_SIGN) |=>
			(o_cfg.output_pin_polarity == $past(st_r.shift[7:4])
			&& o_cfg.data_sign_select == $past(st_r.shift[3:0]))
	) else $error("sign register not written");

	addr_ack_a: assert property (
		@(posedge i_clk) disable iff (i_reset)
		(st_r.fsm == ST_ADDR && scl_fall && !bus_start && !bus_stop
			&& st_r.bitcnt == BITS_BYTE && st_r.shift[7:1] == BUS_ADDR)
			|=> (o_sda_oe && st_r.fsm == ST_ACK)
	) else $error("own address not acknowledged");
endmodule

/* bench/testbench.sv */
`timescale 1ns/10ps
module testbench import bac_pkg::*; ;
	// clock, reset and serial pins
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic i_scl = 1'b1;
	logic sda_m = 1'b1; // master drive, released is high
	logic i_sda;
	logic o_sda;
	logic o_sda_oe;
	// algorithm side
	logic [NCH-1:0][SCYC_W-1:0] cyc = '0;
	logic vld = 1'b0;
	logic [NCH-1:0][VAL_W-1:0] val = '0;
	logic [VAL_W-1:0] thr = 16'h0020;
	bac_cfg_t cfg;
	logic [NCH-1:0][WIN_W-1:0] win;
	logic [NCH-1:0] pin;
	logic tvoid;
	// bookkeeping
	int num_errors = 0;
	int num_checks = 0;
	int seed = 32'hee04;
	logic [15:0] exp_q[$];
	string nm_q[$];
	logic [15:0] got_val;
	event got;
	logic [NCH-1:0] prs = '0; // modelled pressed state
	logic [7:0] ofs_t[5] = '{8'h17, 8'h18, 8'h19, 8'h1a, 8'h1c};
	logic [7:0] rst_t[5] = '{8'h03, 8'h08, 8'h00, 8'h00, 8'h0f};
	logic [7:0] sh[5]; // shadow of the register contents

	// open-drain wire: pulled up unless the master or the device pulls low
	assign i_sda = sda_m & ~o_sda_oe;

	bac_cfg_top dut (.i_clk(i_clk), .i_reset(i_reset), .i_scl(i_scl), .i_sda(i_sda),
		.o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_sensor_cycle_count(cyc),
		.i_value_valid(vld), .i_button_value(val), .i_trigger_threshold(thr), .o_cfg(cfg),
		.o_sample_window(win), .o_button_output_pin(pin), .o_twist_void(tvoid));

	// free-running clock
	initial begin
		forever #20 i_clk = ~i_clk;
	end

	// compare one observation with its note
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] e);
		num_checks++;
		if (seen !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, seen);
		end
	endtask

	// note the expectation and present the observed value
	task automatic note(input string nm, input logic [15:0] e, input logic [15:0] v);
		exp_q.push_back(e);
		nm_q.push_back(nm);
		got_val = v;
		->got;
		#1;
	endtask

	// monitor takes the oldest note for each observation
	initial begin
		forever begin
			@(got);
			check(nm_q.pop_front(), got_val, exp_q.pop_front());
		end
	end

	// counts, verdict and end of run
	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// hang guard
	initial begin
		repeat (50000) @(posedge i_clk);
		num_errors++;
		close_out();
	end

	// one bus phase held for seven clocks, well over the low-time minimum
	task automatic ph(input logic s, input logic d);
		@(posedge i_clk);
		i_scl <= s;
		sda_m <= d;
		repeat (6) @(posedge i_clk);
	endtask

	// one bit slot, data changes only while the clock line is low
	task automatic bitx(input logic b, output logic r);
		ph(1'b0, sda_m);
		ph(1'b0, b);
		ph(1'b1, b);
		r = i_sda;
	endtask

	// start, also serving as repeated start
	task automatic start();
		ph(1'b0, 1'b1);
		ph(1'b1, 1'b1);
		ph(1'b1, 1'b0);
		ph(1'b0, 1'b0);
	endtask

	// stop condition, lines left released
	task automatic stop();
		ph(1'b0, 1'b0);
		ph(1'b1, 1'b0);
		ph(1'b1, 1'b1);
	endtask

	// byte out msb first, then the ack slot
	task automatic wbyte(input logic [7:0] d, output logic a);
		for (int i = 7; i >= 0; i--) bitx(d[i], a);
		bitx(1'b1, a);
	endtask

	// byte in, then master ack or nack
	task automatic rbyte(input logic nak, output logic [7:0] d);
		logic a;
		for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
		bitx(nak, a);
	endtask

	// write n bytes from the pointer onward
	task automatic rwr(input logic [7:0] ofs, input logic [15:0] d, input int n);
		logic a;
		logic na;
		start();
		wbyte({BUS_ADDR, 1'b0}, na);
		wbyte(ofs, a);
		na |= a;
		for (int i = n - 1; i >= 0; i--) begin
			wbyte(d[i*8 +: 8], a);
			na |= a;
		end
		stop();
		note("write ack", 16'h0, {15'h0, na});
	endtask

	// set pointer, repeated start, read n bytes, last one nacked
	task automatic rrd(input logic [7:0] ofs, input int n, output logic [15:0] v);
		logic a;
		logic na;
		start();
		wbyte({BUS_ADDR, 1'b0}, na);
		wbyte(ofs, a);
		na |= a;
		start();
		wbyte({BUS_ADDR, 1'b1}, a);
		na |= a;
		v = '0;
		for (int i = n - 1; i >= 0; i--) rbyte(i == 0, v[i*8 +: 8]);
		stop();
		note("read ack", 16'h0, {15'h0, na});
	endtask

	// exported fields against the shadow copy
	task automatic cchk();
		note("divider", {13'h0, sh[0][2:0]}, {13'h0, cfg.osc_divider_sel});
		note("band", {12'h0, sh[1][3:0]}, {12'h0, cfg.trigger_band});
		note("twist", {13'h0, sh[2][2:0]}, {13'h0, cfg.twist_guard_level});
		note("groups", {8'h0, sh[3]}, {8'h0, cfg.common_group_member,
			cfg.deform_group_member});
		note("signs", {8'h0, sh[4]}, {8'h0, cfg.output_pin_polarity,
			cfg.data_sign_select});
	endtask

	// random cycle counts, then each window checked
	task automatic wchk();
		@(posedge i_clk);
		for (int c = 0; c < NCH; c++) cyc[c] <= 5'($random(seed));
		repeat (3) @(posedge i_clk);
		#1;
		for (int c = 0; c < NCH; c++) begin
			note("window", {4'h0, 12'(cyc[c]) << sh[0][2:0]}, {4'h0, win[c]});
		end
	endtask

	// one sample set against the press and twist model
	task automatic smp(input logic [NCH-1:0][VAL_W-1:0] v);
		int x[NCH];
		int tw;
		int bd;
		int t;
		logic vd;
		logic [NCH-1:0] p;
		tw = int'(sh[2][2:0]);
		bd = int'(sh[1][3:0]);
		t = int'($signed(thr));
		vd = 1'b0;
		for (int c = 0; c < NCH; c++) begin
			x[c] = sh[4][c] ? int'($signed(v[c])) : -int'($signed(v[c]));
			if (tw != 0 && x[c] < -4 * tw) vd = 1'b1;
		end
		for (int c = 0; c < NCH; c++) p[c] = !vd && ((prs[c] && x[c] >= t - 4 * bd) || x[c] >= t);
		@(posedge i_clk);
		vld <= 1'b1;
		val <= v;
		@(posedge i_clk);
		vld <= 1'b0;
		repeat (2) @(posedge i_clk);
		#1;
		prs = p;
		note("pins", {12'h0, ~(p ^ sh[4][7:4])}, {12'h0, pin});
		note("void", {15'h0, vd}, {15'h0, tvoid});
	endtask

	// main sequence
	initial begin
		logic [15:0] rd;
		logic a;
		logic [NCH-1:0][VAL_W-1:0] v;
		sh = rst_t;
		repeat (12) @(posedge i_clk);
		i_reset <= 1'b0;
		repeat (4) @(posedge i_clk);
		// reset state of pins and every register
		note("idle pins", 16'h000f, {12'h0, pin});
		note("idle void", 16'h0, {15'h0, tvoid});
		note("sda level", 16'h0, {15'h0, o_sda});
		cchk();
		for (int i = 0; i < 5; i++) begin
			rrd(ofs_t[i], 1, rd);
			note("reset", {8'h0, rst_t[i]}, rd);
		end
		wchk();
		// random contents, reserved bits included, read back
		for (int i = 0; i < 5; i++) begin
			sh[i] = 8'($random(seed));
			rwr(ofs_t[i], {8'h0, sh[i]}, 1);
			rrd(ofs_t[i], 1, rd);
			note("readback", {8'h0, sh[i]}, rd);
		end
		cchk();
		wchk();
		// foreign address gets no ack
		start();
		wbyte({BUS_ADDR ^ 7'h01, 1'b0}, a);
		stop();
		note("foreign", 16'h1, {15'h0, a});
		// burst write from the group register on into unmapped 1b, burst read back
		sh[3] = 8'h5a;
		rwr(8'h1a, {sh[3], 8'hff}, 2);
		rrd(8'h1a, 2, rd);
		note("burst", {sh[3], 8'h00}, rd);
		// second reset in mid-run
		@(posedge i_clk);
		i_reset <= 1'b1;
		repeat (3) @(posedge i_clk);
		i_reset <= 1'b0;
		repeat (2) @(posedge i_clk);
		#1;
		sh = rst_t;
		prs = '0;
		cchk();
		// algorithm under several settings, first with twist off
		for (int k = 0; k < 4; k++) begin
			// random trigger level, settled long before the first sample
			thr <= 16'($random(seed) % 64);
			sh[1] = {4'h0, 4'($random(seed))};
			sh[2] = (k == 0) ? 8'h00 : {5'h0, 3'($random(seed))};
			sh[4] = 8'($random(seed));
			rwr(8'h18, {sh[1], sh[2]}, 2);
			rwr(8'h1c, {8'h0, sh[4]}, 1);
			cchk();
			for (int j = 0; j < 20; j++) begin
				for (int c = 0; c < NCH; c++) v[c] = 16'($random(seed) % 160);
				smp(v);
			end
		end
		close_out();
	end
endmodule
